//--- logic/gtmr_map.vh
`ifndef GTMR_MAP_VH
`define GTMR_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets, byte wide registers on an 8-bit address
`define GTMR_OFS_CONFIG 8'h50
`define GTMR_OFS_RESTART_PEND 8'h51
`define GTMR_OFS_T0_CMP 8'h53
`define GTMR_OFS_RSVD_GAP 8'h54
`define GTMR_OFS_T1_CMP 8'h55
`define GTMR_OFS_T2_CMP_HI 8'h56
`define GTMR_OFS_T2_CMP_LO 8'h57
`define GTMR_OFS_T3_CMP_HI 8'h58
`define GTMR_OFS_T3_CMP_LO 8'h59
`define GTMR_OFS_IRQ_MASK 8'h5A
`define GTMR_OFS_T0_COUNT 8'h5B
`define GTMR_OFS_T1_COUNT 8'h5C
`define GTMR_OFS_T2_COUNT_HI 8'h5D
`define GTMR_OFS_T2_COUNT_LO 8'h5E
`define GTMR_OFS_T3_COUNT_HI 8'h5F
`define GTMR_OFS_T3_COUNT_LO 8'h60

////////////////////////////////////////////////////////////////////////////////
// field positions
`define GTMR_CFG_TEST_BIT 4
`define GTMR_CFG_EN_MSB 3
`define GTMR_CFG_EN_LSB 0
`define GTMR_PEND_RESTART_MSB 7
`define GTMR_PEND_RESTART_LSB 4
`define GTMR_PEND_FLAG_MSB 3
`define GTMR_PEND_FLAG_LSB 0

////////////////////////////////////////////////////////////////////////////////
// reset values
`define GTMR_RST_CONFIG 5'h00
`define GTMR_RST_PEND 4'h0
`define GTMR_RST_CMP 8'h00
`define GTMR_RST_MASK 4'hF
`define GTMR_RST_COUNT 16'h0000

////////////////////////////////////////////////////////////////////////////////
// timing: main clock 100 MHz, low-frequency tick 32.768 kHz, both in Hz
`define GTMR_CLK_HZ 27'h5F5E100
`define GTMR_LF_HZ 27'h0008000

`endif

//--- logic/gtmr_timer.v
`timescale 1ns/10ps

`include "gtmr_map.vh"

module gtmr_timer #(
	parameter NARROW_WIDTH = 8,
	parameter WIDE_WIDTH = 16
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire [7:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output wire [7:0] rdata_out,
	output wire irq_out
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	reg rst_sync1_q;
	reg rst_sync2_q;
	wire rst_n;
	reg [26:0] phase_q;
	reg [26:0] phase_d;
	reg lf_tick_q;
	reg lf_tick_d;
	wire tick;
	reg [4:0] cfg_q;
	reg [3:0] pend_q;
	reg [3:0] pend_d;
	reg [3:0] mask_q;
	reg [7:0] cmp0_q;
	reg [7:0] cmp1_q;
	reg [7:0] cmp2h_q;
	reg [7:0] cmp2l_q;
	reg [7:0] cmp3h_q;
	reg [7:0] cmp3l_q;
	reg [15:0] cnt_q [0:3];
	reg [15:0] cmp_w [0:3];
	reg [3:0] match_w;
	reg [3:0] restart_w;
	reg [3:0] clear_w;
	reg [7:0] rdata_q;
	reg [7:0] rdata_d;
	wire [3:0] enable;
	wire wr_pend;
	integer i;
	// the clocked loops get their own index so that no variable has two writers
	integer j;

	////////////////////////////////////////////////////////////////////////////////
	// functions

	// mask a count to the width of its timer, so the narrow ones wrap at 256
	function [15:0] gtmr_fit;
		input [15:0] value;
		input integer idx;
		reg [15:0] narrow_mask;
		reg [15:0] wide_mask;
		begin
			narrow_mask = (16'h0001 << NARROW_WIDTH) - 16'h0001;
			wide_mask = (WIDE_WIDTH >= 16) ? 16'hFFFF : ((16'h0001 << WIDE_WIDTH) - 16'h0001);
			if (idx < 2) begin
				gtmr_fit = value & narrow_mask;
			end else begin
				gtmr_fit = value & wide_mask;
			end
		end
	endfunction

	// one step of a counter: back to zero on match, else up by one
	// a compare lowered below the running count costs one full wrap before it matches
	function [15:0] gtmr_step;
		input [15:0] count;
		input matched;
		input integer idx;
		begin
			if (matched) begin
				gtmr_step = `GTMR_RST_COUNT;
			end else begin
				gtmr_step = gtmr_fit(count + 16'h0001, idx);
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// reset release through two flops; assertion stays asynchronous
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync1_q <= 1'b0;
			rst_sync2_q <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_sync2_q <= rst_sync1_q;
		end
	end

	// every flop below resets from this released copy, so none leaves reset early
	assign rst_n = rst_sync2_q;

	////////////////////////////////////////////////////////////////////////////////
	// low-frequency tick as a fractional divider of the main clock
	// a phase accumulator keeps the long-run rate exact at 32.768 kHz;
	// the trade is one main-clock cycle of jitter on each tick
	always @* begin
		phase_d = phase_q + `GTMR_LF_HZ;
		lf_tick_d = 1'b0;
		if (phase_d >= `GTMR_CLK_HZ) begin
			phase_d = phase_d - `GTMR_CLK_HZ;
			lf_tick_d = 1'b1;
		end
	end

	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= 27'h0000000;
			lf_tick_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			lf_tick_q <= lf_tick_d;
		end
	end

	// the tick is a one-cycle enable, never a derived clock, so one clock serves all
	// test mode steps every main clock cycle
	assign tick = cfg_q[`GTMR_CFG_TEST_BIT] ? 1'b1 : lf_tick_q;

	////////////////////////////////////////////////////////////////////////////////
	// control decode
	assign enable = cfg_q[`GTMR_CFG_EN_MSB:`GTMR_CFG_EN_LSB];
	assign wr_pend = wr_in && (addr_in == `GTMR_OFS_RESTART_PEND);

	// restart and clear strobes from a write to the pending register
	always @* begin
		restart_w = 4'h0;
		clear_w = 4'h0;
		if (wr_pend) begin
			restart_w = wdata_in[`GTMR_PEND_RESTART_MSB:`GTMR_PEND_RESTART_LSB];
			clear_w = wdata_in[`GTMR_PEND_FLAG_MSB:`GTMR_PEND_FLAG_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare values, narrow ones zero-extended
	// one comparator width then serves all four timers
	always @* begin
		cmp_w[0] = {8'h00, cmp0_q};
		cmp_w[1] = {8'h00, cmp1_q};
		cmp_w[2] = {cmp2h_q, cmp2l_q};
		cmp_w[3] = {cmp3h_q, cmp3l_q};
	end

	// match of the full compare value on a counting tick
	// narrow compares are cut to their width so a stale high byte never blocks a match
	always @* begin
		for (i = 0; i < 4; i = i + 1) begin
			match_w[i] = tick && enable[i] && (cnt_q[i] == gtmr_fit(cmp_w[i], i));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// counters; a forced restart beats a tick in the same cycle
	// a disabled timer holds its count rather than clearing it
	// the restart winning lets software realign a running timer without disabling it
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			for (j = 0; j < 4; j = j + 1) begin
				cnt_q[j] <= `GTMR_RST_COUNT;
			end
		end else begin
			for (j = 0; j < 4; j = j + 1) begin
				if (restart_w[j]) begin
					cnt_q[j] <= `GTMR_RST_COUNT;
				end else if (tick && enable[j]) begin
					cnt_q[j] <= gtmr_step(cnt_q[j], match_w[j], j);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pending flags: a match in the cycle of a clearing write still sets the flag
	// so no match is lost to a clear that software meant for an older event
	always @* begin
		pend_d = (pend_q & ~clear_w) | match_w;
	end

	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= `GTMR_RST_PEND;
		end else begin
			pend_q <= pend_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software registers
	// writes to the read-only count offsets fall to the default branch and are dropped
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= `GTMR_RST_CONFIG;
			mask_q <= `GTMR_RST_MASK;
			cmp0_q <= `GTMR_RST_CMP;
			cmp1_q <= `GTMR_RST_CMP;
			cmp2h_q <= `GTMR_RST_CMP;
			cmp2l_q <= `GTMR_RST_CMP;
			cmp3h_q <= `GTMR_RST_CMP;
			cmp3l_q <= `GTMR_RST_CMP;
		end else if (wr_in) begin
			case (addr_in)
				`GTMR_OFS_CONFIG: begin
					cfg_q <= wdata_in[4:0];
				end
				`GTMR_OFS_RESTART_PEND: begin
					cfg_q <= cfg_q; // acts through restart_w and clear_w
				end
				`GTMR_OFS_RSVD_GAP: begin
					cfg_q <= cfg_q; // reserved byte, write dropped
				end
				`GTMR_OFS_T0_CMP: begin
					cmp0_q <= wdata_in;
				end
				`GTMR_OFS_T1_CMP: begin
					cmp1_q <= wdata_in;
				end
				`GTMR_OFS_T2_CMP_HI: begin
					cmp2h_q <= wdata_in;
				end
				`GTMR_OFS_T2_CMP_LO: begin
					cmp2l_q <= wdata_in;
				end
				`GTMR_OFS_T3_CMP_HI: begin
					cmp3h_q <= wdata_in;
				end
				`GTMR_OFS_T3_CMP_LO: begin
					cmp3l_q <= wdata_in;
				end
				`GTMR_OFS_IRQ_MASK: begin
					mask_q <= wdata_in[3:0];
				end
				default: begin
					cfg_q <= cfg_q;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux; restart bits and reserved bits read zero
	// the counts are sampled live, so a 16-bit count read as two bytes may tear
	// an unmapped or idle read returns zero, never stale data
	always @* begin
		rdata_d = 8'h00;
		if (rd_in) begin
			case (addr_in)
				`GTMR_OFS_CONFIG: begin
					rdata_d = {3'h0, cfg_q};
				end
				`GTMR_OFS_RESTART_PEND: begin
					rdata_d = {4'h0, pend_q};
				end
				`GTMR_OFS_RSVD_GAP: begin
					rdata_d = 8'h00; // reserved byte reads zero
				end
				`GTMR_OFS_T0_CMP: begin
					rdata_d = cmp0_q;
				end
				`GTMR_OFS_T1_CMP: begin
					rdata_d = cmp1_q;
				end
				`GTMR_OFS_T2_CMP_HI: begin
					rdata_d = cmp2h_q;
				end
				`GTMR_OFS_T2_CMP_LO: begin
					rdata_d = cmp2l_q;
				end
				`GTMR_OFS_T3_CMP_HI: begin
					rdata_d = cmp3h_q;
				end
				`GTMR_OFS_T3_CMP_LO: begin
					rdata_d = cmp3l_q;
				end
				`GTMR_OFS_IRQ_MASK: begin
					rdata_d = {4'h0, mask_q};
				end
				`GTMR_OFS_T0_COUNT: begin
					rdata_d = cnt_q[0][7:0];
				end
				`GTMR_OFS_T1_COUNT: begin
					rdata_d = cnt_q[1][7:0];
				end
				`GTMR_OFS_T2_COUNT_HI: begin
					rdata_d = cnt_q[2][15:8];
				end
				`GTMR_OFS_T2_COUNT_LO: begin
					rdata_d = cnt_q[2][7:0];
				end
				`GTMR_OFS_T3_COUNT_HI: begin
					rdata_d = cnt_q[3][15:8];
				end
				`GTMR_OFS_T3_COUNT_LO: begin
					rdata_d = cnt_q[3][7:0];
				end
				default: begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	// read data stand one cycle after the strobe and read zero otherwise
	// zero when idle lets several blocks share one or-combined read bus
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata_out = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// interrupt: level while a flag of an enabled, unmasked timer is set
	// clearing the enable bit silences the line but leaves the flag readable
	// the mask resets to all pass, so out of reset the line follows the enables
	assign irq_out = |(pend_q & enable & mask_q);

endmodule // gtmr_timer

//--- bench/gtmr_timer_monitor.sv
`timescale 1ns/10ps
module gtmr_mon (
	input wire clk_in,
	input wire rst_n_in,
	input wire [7:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire [7:0] rdata_out,
	input wire irq_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// a write followed at once by a read of the same byte
	sequence wr_rd(a);
		wr_in && addr_in == a ##1 rd_in && addr_in == a;
	endsequence
	// plain byte registers give back the byte written two cycles before
	property back(a);
		wr_rd(a) |=> rdata_out == $past(wdata_in, 2);
	endproperty
	cfg_back_a: assert property (wr_rd(8'h50) |=> rdata_out == {3'h0, $past(wdata_in[4:0], 2)})
		else $error("bad config readback");
	t0_cmp_back_a: assert property (back(8'h53))
		else $error("bad timer 0 compare");
	t1_cmp_back_a: assert property (back(8'h55))
		else $error("bad timer 1 compare");
	t2_high_back_a: assert property (back(8'h56))
		else $error("bad timer 2 high byte");
	t2_low_back_a: assert property (back(8'h57))
		else $error("bad timer 2 low byte");
	t3_high_back_a: assert property (back(8'h58))
		else $error("bad timer 3 high byte");
	t3_low_back_a: assert property (back(8'h59))
		else $error("bad timer 3 low byte");
	restart_reads_zero_a: assert property (rd_in && addr_in == 8'h51 |=> rdata_out[7:4] == 4'h0)
		else $error("restart bits not zero");
	gap_reads_zero_a: assert property (rd_in && addr_in == 8'h54 |=> rdata_out == 8'h00)
		else $error("gap byte not zero");
	// all timers off must silence the interrupt at once, pending or not
	off_quiet_a: assert property (wr_in && addr_in == 8'h50 && wdata_in[3:0] == 4'h0 |=> !irq_out)
		else $error("irq with all timers off");
	// every timer masked must silence the interrupt at once as well
	mask_quiet_a: assert property (wr_in && addr_in == 8'h5A && wdata_in[3:0] == 4'h0 |=> !irq_out)
		else $error("irq with every timer masked");
endmodule // gtmr_mon

bind gtmr_timer gtmr_mon i_gtmr_mon (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out);

//--- bench/gtmr_timer_test.sv
`timescale 1ns/10ps
module gtmr_timer_test;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	wire [7:0] rdata_out;
	wire irq_out;
	int bad_count = 0;
	int checked = 0;
	int n;
	logic [7:0] rv;
	logic [7:0] a;
	logic [7:0] d;
	logic [15:0] c;
	logic [7:0] tbl [8] = '{8'h50, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59};

	gtmr_timer i_gtmr_timer (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out);

	// 100 MHz main clock
	always #5 clk_in = ~clk_in;

	////////////////////////////////////////
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// write strobe left high so a read may follow with no gap
	task put(input logic [7:0] ad, input logic [7:0] dv);
		wr_in <= 1'b1;
		rd_in <= 1'b0;
		addr_in <= ad;
		wdata_in <= dv;
		@(posedge clk_in);
	endtask

	task w(input logic [7:0] ad, input logic [7:0] dv);
		put(ad, dv);
		wr_in <= 1'b0;
		@(posedge clk_in);
	endtask

	// data stand only in the cycle after the strobe, so sample mid-cycle
	task rd(input logic [7:0] ad);
		wr_in <= 1'b0;
		rd_in <= 1'b1;
		addr_in <= ad;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		rv = rdata_out;
		@(posedge clk_in);
	endtask

	// count edges until the interrupt shows, bounded
	task waitirq();
		n = 0;
		while (irq_out !== 1'b1 && n < 7000) begin
			@(negedge clk_in);
			n++;
		end
		@(posedge clk_in);
	endtask

	task irqis(input logic e);
		@(negedge clk_in);
		check(16'(irq_out), 16'(e));
		@(posedge clk_in);
	endtask

	// readback of a byte: config keeps five bits, the gap keeps none
	function automatic logic [7:0] back_of(input logic [7:0] ad, input logic [7:0] dv);
		if (ad == 8'h54) return 8'h00;
		if (ad == 8'h50) return dv & 8'h1F;
		return dv;
	endfunction

	// compare byte for a period in microseconds, one slow tick taken as 30 us
	function automatic logic [7:0] cmp_for(input int us);
		return 8'(us / 30);
	endfunction

	// offset of the low count byte of a timer
	function automatic logic [7:0] cnt_lo(input int t);
		return (t < 2) ? 8'h5B + 8'(t) : 8'h5C + 8'(2 * t - 2);
	endfunction

	task results();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(43127));
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		for (int k = 0; k < 12; k++) begin
			a = (k == 11) ? 8'h7F : 8'h50 + 8'(k);
			rd(a);
			check(16'(rv), (a == 8'h5A) ? 16'h000F : 16'h0000);
		end
		for (int k = 0; k < 24; k++) begin
			a = tbl[k % 8];
			d = 8'($urandom);
			put(a, d);
			rd(a);
			check(16'(rv), 16'(back_of(a, d)));
		end
		// test mode; restart while off so no stale count can match early
		for (int i = 0; i < 4; i++) begin
			c = (i < 2) ? 16'($urandom_range(20, 2)) : 16'h0100 + 16'($urandom_range(9, 0));
			w(8'h50, 8'h10);
			w(8'h53 + 8'(2 * i), c[7:0]);
			if (i > 1) w(8'h52 + 8'(2 * i), c[15:8]);
			w(8'h51, 8'hFF);
			w(8'h50, 8'h10 | (8'h01 << i));
			w(8'h51, 8'h10 << i);
			waitirq();
			check(16'(n), c + 16'h0001);
			w(8'h5A, 8'h00);
			irqis(1'b0);
			w(8'h5A, 8'h0F);
			irqis(1'b1);
			w(8'h50, 8'h10);
			irqis(1'b0);
			rd(8'h51);
			check(16'(rv), 16'h0001 << i);
			w(8'h51, 8'h0F);
			rd(8'h51);
			check(16'(rv), 16'h0000);
			// restart while off, then two enabled test-mode cycles leave the count at two
			w(8'h51, 8'h10 << i);
			w(8'h50, 8'h10 | (8'h01 << i));
			w(8'h50, 8'h10);
			rd(cnt_lo(i));
			check(16'(rv), 16'h0002);
			if (i > 1) begin
				rd(cnt_lo(i) - 8'h01);
				check(16'(rv), 16'h0000);
			end
		end
		// low-frequency ticks: a 30 us period gives compare 1, matching on the second tick
		w(8'h53, cmp_for(30));
		w(8'h51, 8'hFF);
		w(8'h50, 8'h01);
		w(8'h51, 8'h10);
		waitirq();
		check(16'(n >= 3052 && n <= 6104), 16'h0001);
		results();
	end

	// hang guard, far beyond the expected run of at most about seven thousand cycles
	initial begin
		#200000;
		bad_count++;
		results();
	end
endmodule // gtmr_timer_test
